// *** common/mem_map_pkg.sv ***
package mem_map_pkg;
  // ----------------------------------------
  // flash program space
  // ----------------------------------------
  localparam logic [15:0] FLASH_LAST_LARGE = 16'h3bff;
  localparam logic [15:0] FLASH_LAST_SMALL = 16'h1fff;
  // ----------------------------------------
  // internal data space
  // ----------------------------------------
  localparam logic [7:0] LOWER_RAM_LAST = 8'h7f;
  localparam logic [7:0] BANK_AREA_LAST = 8'h1f;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam int PSW_BANK_LOW_POS = 3;
  localparam int PSW_BANK_HIGH_POS = 4;
  localparam logic [7:0] SP_RESET = 8'h07;
  // ----------------------------------------
  // special function register offsets
  // ----------------------------------------
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] SFR_DPL = 8'h82;
  localparam logic [7:0] SFR_DPH = 8'h83;
  localparam logic [7:0] SFR_PSW = 8'hd0;
  localparam logic [7:0] SFR_ONCHIP_EXTERNAL_RAM_PAGE = 8'haa;
  localparam logic [7:0] ONCHIP_EXTERNAL_RAM_PAGE_RESET = 8'h00;
  localparam int PAGE_SELECT_POS = 0;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [7:0] DP_RESET = 8'h00;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int IRAM_BYTES = 256;
  localparam int ONCHIP_EXTERNAL_RAM_BYTES = 512;
  localparam int ONCHIP_EXTERNAL_RAM_AW = 9;

  typedef enum logic [2:0] {
    ACC_DIRECT,
    ACC_INDIRECT,
    ACC_BIT,
    ACC_PUSH,
    ACC_POP
  } iram_mode_t;

  typedef enum logic [1:0] {
    XMODE_DATA_POINTER,
    XMODE_R0,
    XMODE_R1
  } xmode_t;

  typedef struct packed {
    logic valid;
    logic write;
    iram_mode_t mode;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic bit_wdata;
  } iram_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    xmode_t mode;
    logic [7:0] wdata;
  } onchip_external_ram_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } code_req_t;
endpackage

// *** hw/onchip_external_ram_store.sv ***
`timescale 1ns/1ps
module onchip_external_ram_store #(
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  input wire logic core_clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// *** hw/data_memory_map.sv ***
`timescale 1ns/1ps
// Contract
// [R1] flash spans zero to 0x3bff or 0x1fff; last byte is lock; above reserved
// [R2] code moves read flash; external writes may be redirected to flash
// [R3] 768 bytes ram: 256 internal, rest on-chip external
// [R4] lower 128 internal bytes reachable by direct and indirect access
// [R5] above 0x7f direct hits special registers, indirect hits upper ram
// [R6] bytes 0..0x1f are four banks; psw bits 3,4 pick the bank
// [R7] indirect pointer comes from index register zero or one of bank
// [R8] bytes 0x20..0x2f also 128 bits; bit address is 8*offset+bit
// [R9] bit or byte access chosen only by operand type
// [R10] stack pointer holds last used; push writes sp+1 then increments
// [R11] reset loads stack pointer with 0x07
// [R12] stack may sit anywhere in 256 internal bytes
// [R13] 512 byte external ram via data pointer or index plus page
// [R14] external moves hit external ram unless flash write enabled
// [R15] external ram needs no setup; normal move timing
// [R16] 16-bit form uses whole data pointer; high and low bytes separate
// [R17] 8-bit form: page register high byte, index register low byte
// [R18] page register bits 7:1 read zero, ignore writes
// [R19] page bit one selects 0x0100..0x01ff, zero selects 0x0000..0x00ff
// [R20] external decode uses low nine bits; higher addresses alias
module data_memory_map
  import mem_map_pkg::*;
#(
  parameter bit LARGE_FLASH = 1'b1
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire mem_map_pkg::iram_req_t iram_req,
  output logic [7:0] iram_rdata,
  output logic iram_rvalid,
  input wire logic sfr_valid,
  input wire logic sfr_write,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  output logic [7:0] sfr_ext_addr,
  output logic sfr_ext_valid,
  input wire logic [7:0] sfr_ext_rdata,
  input wire logic data_pointer_load,
  input wire logic [15:0] data_pointer_value,
  input wire logic data_pointer_inc,
  input wire mem_map_pkg::onchip_external_ram_req_t onchip_external_ram_req,
  input wire logic flash_write_en,
  output logic [7:0] onchip_external_ram_rdata,
  output logic onchip_external_ram_rvalid,
  output logic flash_wr_valid,
  output logic [15:0] flash_wr_addr,
  output logic [7:0] flash_wr_data,
  input wire mem_map_pkg::code_req_t code_req,
  output logic [15:0] flash_rd_addr,
  output logic flash_rd_valid,
  output logic code_reserved,
  output logic code_lock_byte,
  output logic [7:0] stack_pointer,
  output logic [1:0] active_bank
);
  import mem_map_pkg::*;

  // ----------------------------------------
  // architectural registers
  // ----------------------------------------
  logic [7:0] sp_ff, nxt_sp;
  logic [7:0] psw_ff, nxt_psw;
  logic [7:0] dpl_ff, nxt_dpl;
  logic [7:0] dph_ff, nxt_dph;
  logic page_ff, nxt_page;
  // lower 256 bytes of the 768; the rest sits in the external store
  logic [7:0] iram [IRAM_BYTES]; // [R3]
  logic [7:0] iram_rdata_ff;
  logic iram_rvalid_ff;
  logic onchip_external_ram_rvalid_ff;
  logic [7:0] sfr_rdata_ff;
  logic sfr_hit_ff;

  // ----------------------------------------
  // internal ram decode
  // ----------------------------------------
  wire [1:0] bank = {psw_ff[PSW_BANK_HIGH_POS], psw_ff[PSW_BANK_LOW_POS]}; // [R6]
  wire is_direct = iram_req.mode == ACC_DIRECT;
  wire is_bit = iram_req.mode == ACC_BIT;
  wire is_indirect = iram_req.mode == ACC_INDIRECT;
  wire is_push = iram_req.mode == ACC_PUSH;
  wire is_pop = iram_req.mode == ACC_POP;
  // direct above 0x7f goes to special registers, not ram
  wire direct_sfr = is_direct && (iram_req.addr > LOWER_RAM_LAST); // [R5]
  // bit addresses above 0x7f are special register bits, outside this map
  wire bit_sfr = is_bit && iram_req.addr[7]; // [R9]
  wire [7:0] bit_byte_addr = BIT_AREA_BASE + {4'h0, iram_req.addr[6:3]}; // [R8]
  wire [2:0] bit_pos = iram_req.addr[2:0];
  wire [7:0] ptr_addr = {3'h0, bank, 2'h0, iram_req.addr[0]}; // [R7]
  wire [7:0] ind_addr = iram[ptr_addr]; // [R7]
  wire [7:0] sp_plus = sp_ff + 8'h01;
  // full 256 bytes usable; pointer wraps in 8 bits
  wire [7:0] ram_addr =
    is_bit ? bit_byte_addr :
    is_indirect ? ind_addr : // [R5]
    is_push ? sp_plus : // [R10]
    is_pop ? sp_ff : // [R12]
    iram_req.addr; // [R4]
  wire ram_active = iram_req.valid && !direct_sfr && !bit_sfr;
  wire ram_we = ram_active && (iram_req.write || is_push) && !is_pop;
  wire [7:0] old_byte = iram[ram_addr];
  wire [7:0] bit_merged = (old_byte & ~(8'h01 << bit_pos))
    | ({7'h00, iram_req.bit_wdata} << bit_pos); // [R9]
  wire [7:0] ram_wbyte = is_bit ? bit_merged : iram_req.wdata;
  wire [7:0] ram_rbyte = is_bit ? {7'h00, old_byte[bit_pos]} : old_byte; // [R9]

  always_ff @(posedge core_clk) begin
    if (ram_we) begin
      iram[ram_addr] <= ram_wbyte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      iram_rdata_ff <= 8'h00;
      iram_rvalid_ff <= 1'b0;
    end else begin
      iram_rdata_ff <= ram_rbyte;
      iram_rvalid_ff <= ram_active && !ram_we;
    end
  end

  // ----------------------------------------
  // special register port
  // ----------------------------------------
  wire sel_sp = sfr_addr == SFR_SP;
  wire sel_psw = sfr_addr == SFR_PSW;
  wire sel_dpl = sfr_addr == SFR_DPL;
  wire sel_dph = sfr_addr == SFR_DPH;
  wire sel_page = sfr_addr == SFR_ONCHIP_EXTERNAL_RAM_PAGE;
  wire local_sfr = sel_sp | sel_psw | sel_dpl | sel_dph | sel_page;
  wire sfr_wr = sfr_valid && sfr_write;
  wire [7:0] page_read = {7'h00, page_ff}; // [R18]
  wire [7:0] local_rdata =
    sel_sp ? sp_ff :
    sel_psw ? psw_ff :
    sel_dpl ? dpl_ff :
    sel_dph ? dph_ff :
    page_read;

  assign sfr_ext_valid = sfr_valid && !local_sfr;
  assign sfr_ext_addr = sfr_addr;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sfr_rdata_ff <= 8'h00;
      sfr_hit_ff <= 1'b0;
    end else begin
      sfr_rdata_ff <= local_sfr ? local_rdata : sfr_ext_rdata;
      sfr_hit_ff <= sfr_valid && !sfr_write && local_sfr;
    end
  end

  // ----------------------------------------
  // stack, status, pointer, page next state
  // ----------------------------------------
  wire push_go = iram_req.valid && is_push;
  wire pop_go = iram_req.valid && is_pop;
  wire [15:0] data_pointer_plus = {dph_ff, dpl_ff} + 16'h0001;

  always_comb begin
    nxt_sp = sp_ff;
    if (sfr_wr && sel_sp) begin
      nxt_sp = sfr_wdata;
    end else if (push_go) begin
      nxt_sp = sp_plus; // [R10]
    end else if (pop_go) begin
      nxt_sp = sp_ff - 8'h01;
    end
  end

  always_comb begin
    nxt_psw = (sfr_wr && sel_psw) ? sfr_wdata : psw_ff;
    nxt_page = (sfr_wr && sel_page) ? sfr_wdata[PAGE_SELECT_POS] : page_ff; // [R18]
  end

  // 16-bit pointer kept as two bytes for separate access
  always_comb begin
    nxt_dpl = dpl_ff;
    nxt_dph = dph_ff;
    if (data_pointer_load) begin
      nxt_dph = data_pointer_value[15:8];
      nxt_dpl = data_pointer_value[7:0];
    end else if (data_pointer_inc) begin
      nxt_dph = data_pointer_plus[15:8];
      nxt_dpl = data_pointer_plus[7:0];
    end else begin
      if (sfr_wr && sel_dpl) begin
        nxt_dpl = sfr_wdata; // [R16]
      end
      if (sfr_wr && sel_dph) begin
        nxt_dph = sfr_wdata; // [R16]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sp_ff <= SP_RESET; // [R11]
      psw_ff <= PSW_RESET;
      dpl_ff <= DP_RESET;
      dph_ff <= DP_RESET;
      page_ff <= ONCHIP_EXTERNAL_RAM_PAGE_RESET[PAGE_SELECT_POS];
    end else begin
      sp_ff <= nxt_sp;
      psw_ff <= nxt_psw;
      dpl_ff <= nxt_dpl;
      dph_ff <= nxt_dph;
      page_ff <= nxt_page;
    end
  end

  // ----------------------------------------
  // on-chip external ram
  // ----------------------------------------
  wire [7:0] idx_byte = iram[{3'h0, bank, 2'h0, onchip_external_ram_req.mode == XMODE_R1}]; // [R17]
  wire [15:0] x_full = (onchip_external_ram_req.mode == XMODE_DATA_POINTER) ? {dph_ff, dpl_ff} : // [R16]
    {7'h00, page_ff, idx_byte}; // [R19]
  // upper address bits ignored, so large addresses alias
  wire [ONCHIP_EXTERNAL_RAM_AW-1:0] x_addr = x_full[ONCHIP_EXTERNAL_RAM_AW-1:0]; // [R20]
  wire x_to_flash = onchip_external_ram_req.valid && onchip_external_ram_req.write && flash_write_en; // [R2]
  wire x_we = onchip_external_ram_req.valid && onchip_external_ram_req.write && !flash_write_en; // [R14]

  // single-cycle store, no setup needed before first access
  onchip_external_ram_store #(
    .DEPTH(ONCHIP_EXTERNAL_RAM_BYTES),
    .AW(ONCHIP_EXTERNAL_RAM_AW)
  ) u_onchip_external_ram ( // [R13]
    .core_clk(core_clk),
    .we(x_we),
    .addr(x_addr),
    .wdata(onchip_external_ram_req.wdata),
    .rdata(onchip_external_ram_rdata)
  ); // [R15]

  always_ff @(posedge core_clk) begin
    if (reset) begin
      onchip_external_ram_rvalid_ff <= 1'b0;
    end else begin
      onchip_external_ram_rvalid_ff <= onchip_external_ram_req.valid && !onchip_external_ram_req.write;
    end
  end

  assign flash_wr_valid = x_to_flash; // [R2]
  assign flash_wr_addr = x_full;
  assign flash_wr_data = onchip_external_ram_req.wdata;

  // ----------------------------------------
  // program flash reads
  // ----------------------------------------
  wire [15:0] flash_last = LARGE_FLASH ? FLASH_LAST_LARGE : FLASH_LAST_SMALL; // [R1]
  assign flash_rd_valid = code_req.valid; // [R2]
  assign flash_rd_addr = code_req.addr;
  assign code_reserved = code_req.valid && (code_req.addr > flash_last); // [R1]
  assign code_lock_byte = code_req.valid && (code_req.addr == flash_last); // [R1]

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign iram_rdata = iram_rdata_ff;
  assign iram_rvalid = iram_rvalid_ff;
  assign onchip_external_ram_rvalid = onchip_external_ram_rvalid_ff;
  assign sfr_rdata = sfr_rdata_ff;
  assign sfr_hit = sfr_hit_ff;
  assign stack_pointer = sp_ff;
  assign active_bank = bank;
endmodule

// *** testbench/data_memory_map_assertions.sv ***
`timescale 1ns/1ps
module data_memory_map_assertions
  import mem_map_pkg::*;
#(
  parameter bit LARGE_FLASH = 1'b1
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire mem_map_pkg::iram_req_t iram_req,
  input wire logic iram_rvalid,
  input wire logic sfr_valid,
  input wire logic sfr_write,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_ext_addr,
  input wire logic sfr_ext_valid,
  input wire mem_map_pkg::onchip_external_ram_req_t onchip_external_ram_req,
  input wire logic flash_write_en,
  input wire logic flash_wr_valid,
  input wire mem_map_pkg::code_req_t code_req,
  input wire logic [15:0] flash_rd_addr,
  input wire logic flash_rd_valid,
  input wire logic code_reserved,
  input wire logic code_lock_byte,
  input wire logic [7:0] stack_pointer,
  input wire logic [1:0] active_bank
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire [15:0] last = LARGE_FLASH ? FLASH_LAST_LARGE : FLASH_LAST_SMALL;
  wire sp_wr = sfr_valid && sfr_write && sfr_addr == SFR_SP;
  wire mine = sfr_addr inside {SFR_SP, SFR_DPL, SFR_DPH, SFR_PSW, SFR_ONCHIP_EXTERNAL_RAM_PAGE};
  chk_sp_reset: assert property (disable iff (1'b0)
    reset |=> stack_pointer == SP_RESET) else $error("sp reset value wrong");
  chk_push_step: assert property (
    iram_req.valid && iram_req.mode == ACC_PUSH && !sp_wr
    |=> stack_pointer == $past(stack_pointer) + 8'h01) else $error("push step wrong");
  chk_bank_pick: assert property (
    sfr_valid && sfr_write && sfr_addr == SFR_PSW
    |=> active_bank == $past(sfr_wdata[4:3])) else $error("bank select wrong");
  chk_direct_split: assert property (
    iram_req.valid && !iram_req.write && iram_req.mode == ACC_DIRECT
    |=> iram_rvalid == !$past(iram_req.addr[7])) else $error("direct decode wrong");
  chk_sfr_pass: assert property (
    sfr_valid && !mine |-> sfr_ext_valid && sfr_ext_addr == sfr_addr)
    else $error("sfr pass-on wrong");
  chk_code_read: assert property (
    code_req.valid |-> flash_rd_valid && flash_rd_addr == code_req.addr)
    else $error("code read wrong");
  chk_lock_byte: assert property (
    code_req.valid |-> code_lock_byte == (code_req.addr == last)
    && code_reserved == (code_req.addr > last)) else $error("lock decode wrong");
  chk_flash_redir: assert property (
    onchip_external_ram_req.valid && onchip_external_ram_req.write |-> flash_wr_valid == flash_write_en)
    else $error("flash redirect wrong");
endmodule

bind data_memory_map data_memory_map_assertions #(.LARGE_FLASH(LARGE_FLASH)) i_chk (.*);

// *** testbench/core_model.sv ***
`timescale 1ns/1ps
module core_model
  import mem_map_pkg::*;
(
  input wire logic core_clk,
  input wire logic [7:0] iram_rdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_ext_valid,
  input wire logic [7:0] onchip_external_ram_rdata,
  input wire logic code_lock_byte,
  input wire logic code_reserved,
  output mem_map_pkg::iram_req_t iram_req,
  output mem_map_pkg::onchip_external_ram_req_t onchip_external_ram_req,
  output mem_map_pkg::code_req_t code_req,
  output logic sfr_valid,
  output logic sfr_write,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic [7:0] sfr_ext_rdata,
  output logic data_pointer_load,
  output logic [15:0] data_pointer_value,
  output logic data_pointer_inc,
  output logic flash_write_en
);
  logic [7:0] junk = 8'h00;
  // ----
  // unselected peripheral bus churns, so stale data never passes
  // ----
  always @(posedge core_clk) junk <= junk + 8'h3b;
  assign sfr_ext_rdata = sfr_ext_valid ? 8'h5a : junk;
  initial begin
    iram_req = '0;
    onchip_external_ram_req = '0;
    code_req = '0;
    {sfr_valid, sfr_write, sfr_addr, sfr_wdata} = '0;
    {data_pointer_load, data_pointer_value, data_pointer_inc, flash_write_en} = '0;
  end
  task automatic iop(input logic w, iram_mode_t m, logic [7:0] a, d, output logic [7:0] q);
    @(posedge core_clk);
    iram_req <= '{1'b1, w, m, a, d, d[0]};
    @(posedge core_clk);
    iram_req.valid <= 1'b0;
    #1 q = iram_rdata;
  endtask
  task automatic sop(input logic w, logic [7:0] a, d, output logic [7:0] q);
    @(posedge core_clk);
    {sfr_valid, sfr_write, sfr_addr, sfr_wdata} <= {1'b1, w, a, d};
    @(posedge core_clk);
    sfr_valid <= 1'b0;
    #1 q = sfr_rdata;
  endtask
  task automatic xop(input logic w, xmode_t m, logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk);
    onchip_external_ram_req <= '{1'b1, w, m, d};
    @(posedge core_clk);
    onchip_external_ram_req.valid <= 1'b0;
    #1 q = onchip_external_ram_rdata;
  endtask
  task automatic dp(input logic [15:0] v);
    @(posedge core_clk);
    {data_pointer_load, data_pointer_value} <= {1'b1, v};
    @(posedge core_clk);
    data_pointer_load <= 1'b0;
  endtask
  task automatic cop(input logic [15:0] a, output logic lk, rs);
    @(posedge core_clk);
    code_req <= '{1'b1, a};
    #1 lk = code_lock_byte;
    rs = code_reserved;
    @(posedge core_clk);
    code_req.valid <= 1'b0;
  endtask
endmodule

// *** testbench/data_memory_map_tb.sv ***
`timescale 1ns/1ps
module data_memory_map_tb;
  import mem_map_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  iram_req_t iram_req;
  onchip_external_ram_req_t onchip_external_ram_req;
  code_req_t code_req;
  logic [7:0] iram_rdata, sfr_addr, sfr_wdata, sfr_rdata, sfr_ext_addr, sfr_ext_rdata;
  logic [7:0] onchip_external_ram_rdata, flash_wr_data, stack_pointer, q;
  logic [15:0] data_pointer_value, flash_wr_addr, flash_rd_addr;
  logic iram_rvalid, sfr_valid, sfr_write, sfr_hit, sfr_ext_valid, data_pointer_load, data_pointer_inc;
  logic flash_write_en, onchip_external_ram_rvalid, flash_wr_valid, flash_rd_valid, code_reserved;
  logic code_lock_byte, lk, rs;
  logic [1:0] active_bank;
  int bad_count = 0;
  int checks_done = 0;
  data_memory_map i_dut (.*);
  core_model i_core (.*);
  initial forever #10 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [15:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic stop_test();
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    #1 chk("sp", 8'h07, stack_pointer);
    i_core.sop(1'b1, SFR_ONCHIP_EXTERNAL_RAM_PAGE, 8'hff, q);
    i_core.sop(1'b0, SFR_ONCHIP_EXTERNAL_RAM_PAGE, 8'h00, q);
    chk("page", 8'h01, q);
  endtask
  task automatic t_onchip_external_ram();
    i_core.sop(1'b1, SFR_PSW, 8'h10, q);
    chk("bank", 2'h2, active_bank);
    i_core.iop(1'b1, ACC_DIRECT, 8'h10, 8'h34, q);
    i_core.xop(1'b1, XMODE_R0, 8'ha5, q);
    i_core.sop(1'b1, SFR_DPH, 8'h01, q);
    i_core.sop(1'b1, SFR_DPL, 8'h34, q);
    i_core.xop(1'b0, XMODE_DATA_POINTER, 8'h00, q);
    chk("xr_page1", 8'ha5, q);
    chk("xr_rvalid", 1'b1, onchip_external_ram_rvalid);
    i_core.dp(16'h0334);
    i_core.xop(1'b0, XMODE_DATA_POINTER, 8'h00, q);
    chk("xr_alias", 8'ha5, q);
    i_core.dp(16'h0034);
    i_core.xop(1'b1, XMODE_DATA_POINTER, 8'h3c, q);
    i_core.sop(1'b1, SFR_ONCHIP_EXTERNAL_RAM_PAGE, 8'h00, q);
    i_core.xop(1'b0, XMODE_R0, 8'h00, q);
    chk("xr_page0", 8'h3c, q);
  endtask
  task automatic t_upper();
    // bank 2 is active here, so its first index register sits at 0x10
    i_core.iop(1'b1, ACC_DIRECT, 8'h10, 8'h90, q);
    i_core.iop(1'b1, ACC_INDIRECT, 8'h00, 8'h3c, q);
    i_core.iop(1'b1, ACC_DIRECT, 8'h40, 8'h66, q);
    i_core.iop(1'b1, ACC_DIRECT, 8'h90, 8'h11, q);
    i_core.iop(1'b0, ACC_INDIRECT, 8'h00, 8'h00, q);
    chk("upper", 8'h3c, q);
    i_core.iop(1'b0, ACC_DIRECT, 8'h40, 8'h00, q);
    chk("lower", 8'h66, q);
    i_core.iop(1'b0, ACC_DIRECT, 8'h90, 8'h00, q);
    chk("no_rvalid", 1'b0, iram_rvalid);
    i_core.sop(1'b0, 8'h90, 8'h00, q);
    chk("sfr_ext", 8'h5a, q);
  endtask
  task automatic t_bits();
    i_core.iop(1'b1, ACC_DIRECT, 8'h22, 8'h0c, q);
    i_core.iop(1'b0, ACC_BIT, 8'h13, 8'h00, q);
    chk("bit13", 8'h01, q);
    i_core.iop(1'b1, ACC_BIT, 8'h13, 8'h00, q);
    i_core.iop(1'b0, ACC_DIRECT, 8'h22, 8'h00, q);
    chk("bit_only", 8'h04, q);
  endtask
  task automatic t_stack();
    i_core.iop(1'b1, ACC_PUSH, 8'h00, 8'h55, q);
    chk("sp_push", 8'h08, stack_pointer);
    i_core.iop(1'b0, ACC_DIRECT, 8'h08, 8'h00, q);
    chk("push_at", 8'h55, q);
    i_core.iop(1'b0, ACC_POP, 8'h00, 8'h00, q);
    chk("pop", 8'h55, q);
  endtask
  task automatic t_code();
    @(posedge core_clk);
    i_core.flash_write_en <= 1'b1;
    i_core.xop(1'b1, XMODE_DATA_POINTER, 8'h77, q);
    i_core.cop(16'h3bff, lk, rs);
    chk("lock", 1'b1, lk);
    i_core.cop(16'h3c00, lk, rs);
    chk("reserved", 1'b1, rs);
    i_core.flash_write_en <= 1'b0;
    i_core.xop(1'b0, XMODE_DATA_POINTER, 8'h00, q);
    chk("no_xwrite", 8'h3c, q);
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_onchip_external_ram();
    t_upper();
    t_bits();
    t_stack();
    t_code();
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    stop_test();
  end
endmodule
